// ---- core/ssr_params.svh ----
// register offsets, field positions and reset values of the sync receiver
`ifndef SSR_PARAMS_SVH
`define SSR_PARAMS_SVH

`define SSR_OFF_BAUD1    8'h00
`define SSR_OFF_BAUD2    8'h04
`define SSR_OFF_RXDATA   8'h08
`define SSR_OFF_RXSTAT   8'h0c
`define SSR_OFF_DIVLO    8'h10
`define SSR_OFF_DIVHI    8'h14
`define SSR_OFF_TXSTAT   8'h18
`define SSR_OFF_FIFOSTAT 8'h1c

// receive_status_control
`define SSR_RC_PORT_EN 7
`define SSR_RC_WIDE_EN 6
`define SSR_RC_ONE_EN  5
`define SSR_RC_RUN_EN  4
`define SSR_RC_OVR     1
`define SSR_RC_NINTH   0
// transmit_status_control
`define SSR_TX_MASTER 7
`define SSR_TX_SYNC   4
`define SSR_TX_FAST   2
`define SSR_TX_TRMT   1
// baud_control_first / second
`define SSR_BC_IDLE 6
`define SSR_BC_POL  4
`define SSR_BC_WIDE 3

`define SSR_RST_BYTE  8'h00
`define SSR_RST_WORD  32'h0000_0000
`define SSR_BITS_NARROW 4'h8
`define SSR_BITS_WIDE   4'h9

`endif

// ---- core/ssr_pkg.sv ----
// types shared by the sync receiver modules
package ssr_pkg;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_LEAD,
    PH_TRAIL,
    PH_SLAVE
  } ssr_phase_t;

  typedef struct packed {
    logic [7:0]      baud1;
    logic [7:0]      baud2;
    logic [7:0]      div_lo;
    logic [7:0]      div_hi;
    logic            port_en;
    logic            wide_en;
    logic            one_en;
    logic            run_en;
    logic            master_sel;
    logic            sync;
    logic            fast_sel;
    logic [1:0][8:0] fifo;
    logic [1:0]      cnt;
    logic            ovr;
    logic            ovr_cont;
    logic [8:0]      shreg;
    logic [3:0]      bits;
    ssr_phase_t      phase;
    logic [15:0]     div;
    logic            clk_lvl;
    logic            sclk_prev;
    logic            clk_out;
    logic            clk_oe_n;
    logic            pending;
    logic            pready;
    logic            pslverr;
    logic            pop_arm;
    logic [31:0]     prdata;
  } ssr_state_t;

endpackage : ssr_pkg

// ---- core/ssr_sync.sv ----
// two-flop synchroniser for pin inputs
module ssr_sync #(
  parameter int W = 2
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] d_out
);

  logic [1:0][W-1:0] stage_r;
  logic [1:0][W-1:0] stage_nxt;

  // only the second stage is read outside
  always_comb begin
    stage_nxt[0] = d_in;
    stage_nxt[1] = stage_r[0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_r <= '0;
    end else begin
      stage_r <= stage_nxt;
    end
  end

  assign d_out = stage_r[1];

endmodule : ssr_sync

// ---- core/ssr_rx.sv ----
// synchronous serial receive path with apb registers
//
// How it works
// - reception starts on single or continuous enable
// - master single: one character, then self-clear
// - master continuous: clock runs until enable cleared or overrun
// - continuous cleared mid-character: stop, discard
// - both set: single clears after first character
// - data sampled on trailing shift clock edge
// - complete character pushed to fifo, pending set
// - data register shows oldest entry low byte
// - pending stays set while fifo holds data
// - slave takes clock from line, never drives
// - slave shifts one bit per received clock
// - third character with full fifo sets overrun
// - overrun keeps fifo, blocks further reception
// - single-mode overrun cleared by data read
// - continuous overrun cleared by enable or port
// - nine-bit mode shifts nine bits per character
// - ninth bit of oldest entry readable first
// - clock source select picks master or slave
// - receiver when any receive enable is set
// - port enable clear resets receive logic
// - master drives shift clock onto line
// - idle polarity picks idle level and edges
`include "ssr_params.svh"

module ssr_rx import ssr_pkg::*; (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        data_line_in,
  input  wire logic        clock_line_in,
  output logic             clock_line_out,
  output logic             clock_line_oe_n,
  output logic             rx_pending
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction : hit

  function automatic logic [15:0] half_count(input ssr_state_t s);
    return s.baud1[`SSR_BC_WIDE] ? {s.div_hi, s.div_lo}
                                 : {8'h00, s.div_lo};
  endfunction : half_count

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [1:0] pins_s;
  logic       data_s;
  logic       sclk_s;

  ssr_sync #(.W(2)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d_in    ({clock_line_in, data_line_in}),
    .d_out   (pins_s)
  );

  assign data_s = pins_s[0];
  assign sclk_s = pins_s[1];

  ////////////////////////////////////////////////////////////////////////////
  // state

  ssr_state_t st_r;
  ssr_state_t st_nxt;
  logic       fin;
  logic       done;
  logic       smp;
  logic       pop;
  logic       run_ok;
  logic       ckp;

  assign ckp = st_r.baud1[`SSR_BC_POL];
  // overrun blocks the receiver until it is cleared
  assign run_ok = st_r.port_en & st_r.sync & (st_r.one_en | st_r.run_en)
                  & !st_r.ovr;

  always_comb begin
    logic        first;
    logic        abort;
    logic        trail;
    logic [8:0]  sh_new;
    logic [8:0]  chr;
    logic [3:0]  nbits;
    logic [31:0] rd;
    first  = 1'b0;
    abort  = 1'b0;
    trail  = 1'b0;
    sh_new = 9'h000;
    chr    = 9'h000;
    nbits  = 4'h0;
    rd     = `SSR_RST_WORD;
    st_nxt = st_r;
    smp    = 1'b0;
    done   = 1'b0;
    pop    = 1'b0;
    fin    = 1'b0;

    // apb: one wait state, read data captured in the first access cycle, write data taken in the second
    first = psel & penable & !st_r.pready;
    fin   = psel & penable & st_r.pready;
    if (first) begin
      st_nxt.pready  = 1'b1;
      st_nxt.pslverr = 1'b0;
      st_nxt.pop_arm = 1'b0;
      if (hit(paddr, `SSR_OFF_BAUD1)) begin
        rd[7:0] = {1'b0, st_r.phase == PH_IDLE, 1'b0,
                   st_r.baud1[`SSR_BC_POL], st_r.baud1[`SSR_BC_WIDE],
                   3'h0};
      end else if (hit(paddr, `SSR_OFF_BAUD2)) begin
        rd[7:0] = {1'b0, st_r.phase == PH_IDLE, 1'b0,
                   st_r.baud2[`SSR_BC_POL], st_r.baud2[`SSR_BC_WIDE],
                   3'h0};
      end else if (hit(paddr, `SSR_OFF_RXDATA)) begin
        rd[7:0] = st_r.fifo[0][7:0];
        st_nxt.pop_arm = !pwrite && st_r.cnt != 2'h0;
      end else if (hit(paddr, `SSR_OFF_RXSTAT)) begin
        rd[7:0] = {st_r.port_en, st_r.wide_en, st_r.one_en, st_r.run_en,
                   2'h0, st_r.ovr, st_r.fifo[0][8]};
      end else if (hit(paddr, `SSR_OFF_DIVLO)) begin
        rd[7:0] = st_r.div_lo;
      end else if (hit(paddr, `SSR_OFF_DIVHI)) begin
        rd[7:0] = st_r.div_hi;
      end else if (hit(paddr, `SSR_OFF_TXSTAT)) begin
        rd[7:0] = {st_r.master_sel, 2'h0, st_r.sync, 1'b0, st_r.fast_sel,
                   1'b1, 1'b0};
      end else if (hit(paddr, `SSR_OFF_FIFOSTAT)) begin
        rd[2:0] = {st_r.cnt, st_r.pending};
      end else begin
        st_nxt.pslverr = 1'b1;
      end
      st_nxt.prdata = rd;
    end
    if (fin) begin
      st_nxt.pready  = 1'b0;
      st_nxt.pslverr = 1'b0;
      st_nxt.pop_arm = 1'b0;
      pop = st_r.pop_arm;
      if (pwrite) begin
        if (hit(paddr, `SSR_OFF_BAUD1)) begin
          st_nxt.baud1 = pwdata[7:0] & 8'h18;
        end
        if (hit(paddr, `SSR_OFF_BAUD2)) begin
          st_nxt.baud2 = pwdata[7:0] & 8'h18;
        end
        if (hit(paddr, `SSR_OFF_RXSTAT)) begin
          st_nxt.port_en = pwdata[`SSR_RC_PORT_EN];
          st_nxt.wide_en = pwdata[`SSR_RC_WIDE_EN];
          st_nxt.one_en  = pwdata[`SSR_RC_ONE_EN];
          st_nxt.run_en  = pwdata[`SSR_RC_RUN_EN];
        end
        if (hit(paddr, `SSR_OFF_DIVLO)) begin
          st_nxt.div_lo = pwdata[7:0];
        end
        if (hit(paddr, `SSR_OFF_DIVHI)) begin
          st_nxt.div_hi = pwdata[7:0];
        end
        if (hit(paddr, `SSR_OFF_TXSTAT)) begin
          st_nxt.master_sel = pwdata[`SSR_TX_MASTER];
          st_nxt.sync       = pwdata[`SSR_TX_SYNC];
          st_nxt.fast_sel   = pwdata[`SSR_TX_FAST];
        end
      end
    end

    ////////////////////////////////////////////////////////////////////////////
    // shift clock and sampling

    st_nxt.sclk_prev = sclk_s;
    // trailing edge returns the line to its idle level
    trail = ckp ? (sclk_s & !st_r.sclk_prev)
                : (!sclk_s & st_r.sclk_prev);
    nbits = st_r.wide_en ? `SSR_BITS_WIDE : `SSR_BITS_NARROW;

    case (st_r.phase)
      PH_IDLE: begin
        st_nxt.clk_lvl = ckp;
        if (run_ok) begin
          st_nxt.phase = st_r.master_sel ? PH_LEAD : PH_SLAVE;
          st_nxt.div   = half_count(st_r);
        end
      end
      PH_LEAD: begin
        if (st_r.div == 16'h0000) begin
          st_nxt.clk_lvl = !ckp;
          st_nxt.phase   = PH_TRAIL;
          st_nxt.div     = half_count(st_r);
        end else begin
          st_nxt.div = st_r.div - 16'h0001;
        end
      end
      PH_TRAIL: begin
        if (st_r.div == 16'h0000) begin
          st_nxt.clk_lvl = ckp;
          smp            = 1'b1;
          st_nxt.phase   = PH_LEAD;
          st_nxt.div     = half_count(st_r);
        end else begin
          st_nxt.div = st_r.div - 16'h0001;
        end
      end
      PH_SLAVE: begin
        smp = trail;
      end
      default: begin
        st_nxt.phase = PH_IDLE;
      end
    endcase

    if (smp) begin
      // lsb first: a new bit enters at the top
      sh_new = {data_s, st_r.shreg[8:1]};
      st_nxt.shreg = sh_new;
      st_nxt.bits  = st_r.bits + 4'h1;
      if (st_r.bits + 4'h1 == nbits) begin
        done        = 1'b1;
        st_nxt.bits = 4'h0;
      end
    end

    ////////////////////////////////////////////////////////////////////////////
    // fifo, pending and overrun

    if (pop) begin
      st_nxt.fifo[0] = st_r.fifo[1];
      st_nxt.fifo[1] = 9'h000;
      st_nxt.cnt     = st_r.cnt - 2'h1;
      if (st_r.ovr && !st_r.ovr_cont) begin
        st_nxt.ovr = 1'b0;
      end
    end
    if (done) begin
      chr = st_r.wide_en ? sh_new : {1'b0, sh_new[8:1]};
      if (st_r.one_en) begin
        st_nxt.one_en = 1'b0;
        if (!st_r.run_en) begin
          st_nxt.phase   = PH_IDLE;
          st_nxt.clk_lvl = ckp;
        end
      end
      if (st_nxt.cnt == 2'h2) begin
        // stored entries stay untouched; the new one is lost
        st_nxt.ovr      = 1'b1;
        st_nxt.ovr_cont = st_r.run_en;
      end else begin
        st_nxt.fifo[st_nxt.cnt[0]] = chr;
        st_nxt.cnt = st_nxt.cnt + 2'h1;
      end
    end
    if (st_r.ovr && st_r.ovr_cont && !st_r.run_en) begin
      st_nxt.ovr = 1'b0;
    end

    // leaving receive mode drops any partial character at once
    abort = (st_r.phase != PH_IDLE) &&
            (!run_ok || (st_r.phase == PH_SLAVE) == st_r.master_sel);
    if (abort) begin
      st_nxt.phase   = PH_IDLE;
      st_nxt.bits    = 4'h0;
      st_nxt.clk_lvl = ckp;
    end
    if (!st_r.port_en) begin
      st_nxt.fifo    = '0;
      st_nxt.cnt     = 2'h0;
      st_nxt.ovr     = 1'b0;
      st_nxt.bits    = 4'h0;
      st_nxt.shreg   = 9'h000;
      st_nxt.phase   = PH_IDLE;
      st_nxt.clk_lvl = ckp;
    end

    st_nxt.pending  = st_nxt.cnt != 2'h0;
    st_nxt.clk_oe_n = !(st_nxt.port_en & st_nxt.sync
                        & st_nxt.master_sel);
    st_nxt.clk_out  = st_nxt.clk_oe_n ? st_nxt.baud1[`SSR_BC_POL]
                                      : st_nxt.clk_lvl;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r          <= '0;
      st_r.phase    <= PH_IDLE;
      st_r.clk_oe_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata          = st_r.prdata;
  assign pready          = st_r.pready;
  assign pslverr         = st_r.pslverr;
  assign clock_line_out  = st_r.clk_out;
  assign clock_line_oe_n = st_r.clk_oe_n;
  assign rx_pending      = st_r.pending;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  pend_track_a: assert property (
    st_r.pending == (st_r.cnt != 2'h0))
    else $error("pending flag disagrees with fifo level");

  single_done_a: assert property (
    done && st_r.one_en && !st_r.run_en && !(fin && pwrite)
    |=> !st_r.one_en && st_r.phase == PH_IDLE)
    else $error("single reception did not stop");

  both_done_a: assert property (
    done && st_r.one_en && st_r.run_en && !(fin && pwrite)
    |=> !st_r.one_en && st_r.phase != PH_IDLE)
    else $error("single enable not cleared under continuous");

  slave_hiz_a: assert property (
    !st_r.master_sel && !(fin && pwrite) |=> clock_line_oe_n)
    else $error("slave drives the clock line");

  idle_level_a: assert property (
    st_r.phase == PH_IDLE && !pready ##1 st_r.phase == PH_IDLE
    |-> clock_line_out == $past(ckp))
    else $error("clock not at idle level");

  ovr_set_a: assert property (
    done && st_r.cnt == 2'h2 && !pop && st_r.port_en
    |=> st_r.ovr && st_r.cnt == 2'h2)
    else $error("overrun not flagged");

  ovr_keep_a: assert property (
    st_r.ovr && !pop && st_r.port_en |=> $stable(st_r.fifo) && !done)
    else $error("fifo changed during overrun");

  ovr_read_a: assert property (
    st_r.ovr && !st_r.ovr_cont && pop && st_r.port_en |=> !st_r.ovr)
    else $error("read did not clear single-mode overrun");

  abort_a: assert property (
    $fell(st_r.run_en) && !st_r.one_en && st_r.phase != PH_IDLE
    |-> ##1 st_r.phase == PH_IDLE && st_r.bits == 4'h0 ##1 !done)
    else $error("partial character not dropped");

  port_off_a: assert property (
    !st_r.port_en |=> st_r.cnt == 2'h0 && !st_r.ovr
                   && st_r.phase == PH_IDLE)
    else $error("port disable did not reset receiver");

  push_a: assert property (
    done && st_r.cnt == 2'h0 && !pop
    |=> st_r.cnt == 2'h1 && rx_pending)
    else $error("character not stored");

endmodule : ssr_rx

// ---- tb/ssr_far.sv ----
// far-end serial device: data source, and clock source in slave tests
module ssr_far (
  input  wire logic pol,
  input  wire logic dev_clk,
  input  wire logic dev_oe_n,
  output logic      data,
  output logic      line_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [35:0] bits_r;
  int          left_r;
  initial begin
    data = 1'b0;
    line_clk = 1'b0;
    left_r = 0;
  end
  task load(input logic [35:0] b, input int n);
    bits_r = b;
    left_r = n;
  endtask : load
  // new bit on each leading edge, held to the next one; spare edges
  // toggle the line so a stale bit is never read twice
  always @(dev_clk) begin
    if (!dev_oe_n && dev_clk !== pol) begin
      data = left_r > 0 ? bits_r[0] : ~data;
      bits_r = bits_r >> 1;
      left_r--;
    end
  end
  // one 160 ns period per data bit; clock stands idle between frames
  task send(input int n);
    repeat (n) begin
      line_clk = ~pol;
      data = bits_r[0];
      bits_r = bits_r >> 1;
      #80 line_clk = pol;
      #80;
    end
    data = ~data;
  endtask : send
endmodule : ssr_far

// ---- tb/ssr_rx_test.sv ----
// self-checking bench of the sync receiver: apb traffic and link frames
module ssr_rx_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [7:0]  paddr, dv;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, far_data, far_clk, clk_out, clk_oe_n;
  logic        rx_pending, pol, line_clk, oe_q, out_q, drove, watch;
  logic [64:0] exp_q[$];
  logic [64:0] ent;
  logic [31:0] seed = 32'h0001_15f1;
  logic [8:0]  cs[3];
  int          pulses, n, cycles, miscompares, comparisons;

  // pin level: the device drives only while its enable is low
  assign line_clk = clk_oe_n ? far_clk : clk_out;

  ssr_rx uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .data_line_in(far_data),
    .clock_line_in(line_clk), .clock_line_out(clk_out),
    .clock_line_oe_n(clk_oe_n), .rx_pending(rx_pending)
  );
  ssr_far far (
    .pol(pol), .dev_clk(line_clk), .dev_oe_n(clk_oe_n),
    .data(far_data), .line_clk(far_clk)
  );

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic summarize();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m = 32'hffff_ffff,
                    input logic er = 1'b0);
    exp_q.push_back({er, m, e});
    apb(a, 1'b0, 32'h0);
  endtask : rd

  task automatic upto(input int k);
    repeat (5000) if (pulses < k) @(posedge pclk);
  endtask : upto

  // wait out the last half period and the push, then count exactly
  task automatic frame(input int k);
    upto(k);
    repeat (3 * dv + 12) @(posedge pclk);
    chk(32'(pulses), 32'(k));
  endtask : frame

  // apb read checker, leading-edge counter, drive watch and timeout
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      ent = exp_q.pop_front();
      comparisons++;
      if ({pslverr, prdata & ent[63:32]} !== {ent[64], ent[31:0]}) begin
        miscompares++;
        $display("ERROR %0t got %h exp %h", $time, {pslverr, prdata},
                 {ent[64], ent[31:0]});
      end
    end
    if (!clk_oe_n && !oe_q && clk_out !== pol && out_q === pol) pulses++;
    if (watch && clk_oe_n !== 1'b1) drove = 1'b1;
    oe_q = clk_oe_n;
    out_q = clk_out;
  end

  initial begin
    {psel, penable, pwrite, presetn, pol, drove, watch} = 7'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h00, 32'h40);
    rd(8'h08, 32'h0);
    rd(8'h0c, 32'h0);
    rd(8'h18, 32'h02);
    rd(8'h1c, 32'h0);
    // a hole answers with an error and reads zero
    wr(8'h24, 32'hff);
    rd(8'h24, 32'h0, 32'hffff_ffff, 1'b1);
    dv = 8'h04 + 8'(xs() % 8);
    wr(8'h10, {24'h0, dv});
    rd(8'h10, {24'h0, dv});
    rd(8'h14, 32'h0);
    wr(8'h18, 32'h90);
    for (int p = 1; p >= 0; p--) begin
      pol <= p[0];
      wr(8'h00, {27'h0, p[0], 4'h0});
      cs[0] = 9'(xs());
      pulses = 0;
      wr(8'h0c, 32'ha0);
      far.load(36'(cs[0][7:0]), 8);
      // the enable lands at the completing edge; look one edge later
      @(posedge pclk);
      chk(clk_oe_n, 1'b0);
      frame(8);
      chk(rx_pending, 1'b1);
      chk(clk_out, p[0]);
      rd(8'h0c, 32'h80);
      rd(8'h08, {24'h0, cs[0][7:0]});
      repeat (2) @(posedge pclk);
      chk(rx_pending, 1'b0);
      wr(8'h0c, 32'h0);
    end
    // nine-bit characters; the third overruns the full fifo
    for (int k = 0; k < 3; k++) begin
      cs[k] = 9'(xs());
      pulses = 0;
      wr(8'h0c, 32'he0);
      far.load(36'(cs[k]), 9);
      frame(9);
    end
    wr(8'h0c, 32'hc0);
    rd(8'h0c, {31'h61, cs[0][8]});
    rd(8'h1c, 32'h05);
    rd(8'h08, {24'h0, cs[0][7:0]});
    rd(8'h0c, {31'h60, cs[1][8]});
    rd(8'h08, {24'h0, cs[1][7:0]});
    rd(8'h1c, 32'h0);
    // both enables: three characters back to back, then overrun
    for (int k = 0; k < 3; k++) cs[k] = 9'(xs() & 32'hff);
    pulses = 0;
    wr(8'h0c, 32'hb0);
    far.load(36'({cs[2][7:0], cs[1][7:0], cs[0][7:0]}), 24);
    frame(24);
    rd(8'h0c, 32'h92);
    repeat (60) @(posedge pclk);
    chk(32'(pulses), 32'd24);
    wr(8'h0c, 32'h80);
    rd(8'h0c, 32'h80);
    rd(8'h08, {24'h0, cs[0][7:0]});
    rd(8'h08, {24'h0, cs[1][7:0]});
    // continuous enable dropped part way through a character
    pulses = 0;
    wr(8'h0c, 32'h90);
    far.load(36'h0, 0);
    upto(3);
    wr(8'h0c, 32'h80);
    repeat (2) @(posedge pclk);
    n = pulses;
    repeat (60) @(posedge pclk);
    chk(32'(pulses), 32'(n));
    rd(8'h1c, 32'h0);
    // slave: far end clocks one character
    wr(8'h18, 32'h10);
    wr(8'h0c, 32'h90);
    cs[0] = 9'(xs());
    far.load(36'(cs[0][7:0]), 8);
    watch = 1'b1;
    #7;
    far.send(8);
    repeat (20) @(posedge pclk);
    watch = 1'b0;
    chk(drove, 1'b0);
    rd(8'h08, {24'h0, cs[0][7:0]});
    summarize();
  end
endmodule : ssr_rx_test
